//--- src/wdc_pkg.sv
// package of constants and types shared by both ends of the watchdog link
// assumes one clock domain and the plain register port described in the ends
`default_nettype none
package wdc_pkg;
    // ==========================================================
    // device register map, byte addresses
    localparam logic [7:0]  OFS_LOAD         = 8'h00;
    localparam logic [7:0]  OFS_COUNT        = 8'h04;
    localparam logic [7:0]  OFS_CONTROL      = 8'h08;
    localparam logic [7:0]  OFS_ACCESS       = 8'hf0;
    localparam logic [31:0] COUNT_RESET      = 32'h0000_7a12;
    localparam logic [31:0] CONTROL_RESET    = 32'h0000_805c;
    localparam logic [31:0] LOAD_RESET       = 32'h0000_0000;
    // ==========================================================
    // control field positions, and the unlocked bit of the access register
    localparam int          BIT_DBG_HALT     = 15;
    localparam int          BIT_FLAG         = 8;
    localparam int          BIT_IRQ_EN       = 7;
    localparam int          BIT_RST_EN       = 6;
    localparam int          BIT_CNT_EN       = 4;
    localparam int          BIT_CLK_SEL      = 3;
    localparam int          PRS_MSB          = 2;
    localparam int          BIT_UNLOCKED     = 16;
    // ==========================================================
    // access keys and timing
    localparam logic [15:0] KEY_UNLOCK       = 16'ha55a;
    localparam logic [15:0] KEY_RELOAD       = 16'h555a;
    localparam logic [2:0]  XFER_TICKS       = 3'h5;
    // ==========================================================
    // controller register map, byte addresses
    localparam logic [7:0]  HOFS_CFG         = 8'h00;
    localparam logic [7:0]  HOFS_DEV_ADDR    = 8'h04;
    localparam logic [7:0]  HOFS_DEV_WDATA   = 8'h08;
    localparam logic [7:0]  HOFS_DEV_CMD     = 8'h0c;
    localparam logic [7:0]  HOFS_DEV_RDATA   = 8'h10;
    localparam logic [7:0]  HOFS_STATUS      = 8'h14;
    localparam logic [7:0]  HOFS_EXT_DIV     = 8'h18;
    localparam logic [7:0]  EXT_DIV_RESET    = 8'h04;
    // ==========================================================
    // controller sequencer states
    typedef enum logic [2:0] {
        HS_IDLE, HS_KEY, HS_ACCESS, HS_RDWAIT, HS_RELOCK
    } wdc_hstate_t;
endpackage : wdc_pkg
`default_nettype wire

//--- src/wdc_if.sv
// link between the watchdog device and its controlling party
// assumes both ends share one clock; the bench joins them
`default_nettype none
interface wdc_if;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        wdt_reset;
    logic        wdt_irq;
    logic        core_halted;
    logic        sys_rst_src_en;
    logic        ext_clk;
    modport dev (input addr, wdata, wr, rd, core_halted, sys_rst_src_en, ext_clk,
                 output rdata, wdt_reset, wdt_irq);
    modport ctl (output addr, wdata, wr, rd, core_halted, sys_rst_src_en, ext_clk,
                 input rdata, wdt_reset, wdt_irq);
endinterface : wdc_if
`default_nettype wire

//--- src/wdc_prescale.sv
// counter clock prescaler: divides a source enable by 1,4,8..256
// assumes src_tick is a one-cycle enable on the same clock
`default_nettype none
module wdc_prescale (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       src_tick,
    input  wire logic [2:0] code,
    output logic            tick
);
    import wdc_pkg::*;
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } wdc_prs_t;
    wdc_prs_t   st_reg;
    wdc_prs_t   st_next;
    logic [7:0] limit;
    // ==========================================================
    // code to divider
    assign limit = (code == 3'h0) ? 8'h00 : (8'hff >> (3'h7 - code));
    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (src_tick) begin
            if (st_reg.cnt >= limit) begin
                st_next.cnt  = 8'h00;
                st_next.tick = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 8'h01;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign tick = st_reg.tick;
endmodule : wdc_prescale
`default_nettype wire

//--- src/wdc_device.sv
// watchdog down-counter device end
// assumes registers are reached over the link and the party
// keeps the unlock sequence; external clock arrives asynchronously
`default_nettype none
// Function
// - enable starts decrement per prescaled tick
// - software reloads promptly after enabling counter
// - load applies only while enabled, nonzero
// - reload replaces running count with load, except in a cycle where a tick decrements it
// - reset needs own and system enable
// - reset asserted on count 1 to 0
// - interrupt and flag on 1 to 0
// - flag held until nonzero load write or control write with flag bit clear
// - debug halt bit freezes count when halted
// - halt bit clear keeps counting in debug
// - interrupt mode auto reloads after underflow
// - load transfer takes five counter ticks
// - irq and count lag two cycles max
// - select bit picks peripheral or external clock
// - three bit prescaler, down to 1/256
// - timeout is load ticks
// - unlock key written before settings change
// - prescaler codes map 1,4,8..256
// - other key relocks, reload key reloads
module wdc_device (
    // clock and reset
    input  wire logic CLOCK,
    input  wire logic RST,
    // link
    wdc_if.dev        BUS,
    // status
    output logic      UNDERFLOW,
    output logic      UNLOCKED
);
    import wdc_pkg::*;
    typedef struct packed {
        logic [31:0] count;
        logic [31:0] load;
        logic        dbg_halt;
        logic        flag;
        logic        irq_en;
        logic        rst_en;
        logic        cnt_en;
        logic        clk_sel;
        logic [2:0]  prs;
        logic        unlocked;
        logic        pend;
        logic [2:0]  xfer;
        logic [31:0] rdata;
        logic        rst_out;
        logic        irq_out;
        logic [2:0]  ext_sync;
        logic        ext_level;
    } wdc_dev_t;
    wdc_dev_t    st_reg;
    wdc_dev_t    st_next;
    logic        tick;
    logic        ext_rise;
    logic        run;
    logic        xfer_now;
    logic        uf;
    logic [31:0] ctl_view;
    // ==========================================================
    // external clock edge after three-stage sampling
    assign ext_rise = (st_reg.ext_sync[1] == st_reg.ext_sync[2])
                      && (st_reg.ext_sync[2] != st_reg.ext_level) && st_reg.ext_sync[2];
    // ==========================================================
    // counter clock
    wdc_prescale u_prs (
        .clk      (CLOCK),
        .rst      (RST),
        .src_tick (st_reg.clk_sel ? ext_rise : 1'b1),
        .code     (st_reg.prs),
        .tick     (tick)
    );
    // freeze in debug halt; otherwise keep running
    assign run      = st_reg.cnt_en && !(st_reg.dbg_halt && BUS.core_halted);
    // fifth tick moves load into count
    assign xfer_now = st_reg.pend && st_reg.cnt_en && tick && (st_reg.xfer == XFER_TICKS - 3'h1);
    // event on 1 to 0; none while disabled
    assign uf       = run && tick && !xfer_now && (st_reg.count == 32'h0000_0001);
    always_comb begin
        ctl_view                = '0;
        ctl_view[BIT_DBG_HALT]  = st_reg.dbg_halt;
        ctl_view[BIT_FLAG]      = st_reg.flag;
        ctl_view[BIT_IRQ_EN]    = st_reg.irq_en;
        ctl_view[BIT_RST_EN]    = st_reg.rst_en;
        ctl_view[BIT_CNT_EN]    = st_reg.cnt_en;
        ctl_view[BIT_CLK_SEL]   = st_reg.clk_sel;
        ctl_view[PRS_MSB:0]     = st_reg.prs;
    end
    // ==========================================================
    // next state
    always_comb begin
        st_next           = st_reg;
        st_next.ext_sync  = {st_reg.ext_sync[1:0], BUS.ext_clk};
        if (st_reg.ext_sync[1] == st_reg.ext_sync[2]) begin
            st_next.ext_level = st_reg.ext_sync[2];
        end
        st_next.rst_out   = 1'b0;
        st_next.rdata     = '0;
        // register writes
        if (BUS.wr) begin
            case (BUS.addr)
                OFS_ACCESS: begin
                    st_next.unlocked = (BUS.wdata[15:0] == KEY_UNLOCK);
                    if ((BUS.wdata[15:0] == KEY_RELOAD) && st_reg.cnt_en && (st_reg.load != 32'h0)) begin
                        st_next.count = st_reg.load;
                        st_next.pend  = 1'b0;
                    end
                end
                OFS_LOAD: begin
                    if (st_reg.unlocked) begin
                        st_next.load = BUS.wdata;
                        if (BUS.wdata != 32'h0) begin
                            st_next.pend = 1'b1;
                            st_next.xfer = 3'h0;
                            st_next.flag = 1'b0;
                        end
                    end
                end
                OFS_CONTROL: begin
                    if (st_reg.unlocked) begin
                        st_next.dbg_halt = BUS.wdata[BIT_DBG_HALT];
                        st_next.irq_en   = BUS.wdata[BIT_IRQ_EN];
                        st_next.rst_en   = BUS.wdata[BIT_RST_EN];
                        st_next.cnt_en   = BUS.wdata[BIT_CNT_EN];
                        st_next.clk_sel  = BUS.wdata[BIT_CLK_SEL];
                        st_next.prs      = BUS.wdata[PRS_MSB:0];
                        // flag may be cleared here but never set
                        st_next.flag     = st_reg.flag & BUS.wdata[BIT_FLAG];
                    end
                end
                default: begin
                end
            endcase
        end
        // pending load waits for enable, counted in ticks
        if (st_reg.pend && st_reg.cnt_en && tick && !xfer_now) begin
            st_next.xfer = st_reg.xfer + 3'h1;
        end
        if (xfer_now && !(BUS.wr && BUS.addr == OFS_LOAD)) begin
            st_next.count = st_reg.load;
            st_next.pend  = 1'b0;
        end else if (run && tick && (st_reg.count != 32'h0) && !xfer_now) begin
            // decrement; load ticks to flag
            st_next.count = st_reg.count - 32'h1;
        end
        if (uf) begin
            st_next.flag = 1'b1;
            if (st_reg.irq_en && !st_reg.rst_en) begin
                st_next.count = st_reg.load;
            end
            st_next.rst_out = st_reg.rst_en && BUS.sys_rst_src_en;
        end
        st_next.irq_out = st_next.flag && st_next.irq_en;
        if (BUS.rd) begin
            case (BUS.addr)
                OFS_COUNT:   st_next.rdata = st_reg.count;
                OFS_CONTROL: st_next.rdata = ctl_view;
                OFS_ACCESS:  st_next.rdata = {15'h0000, st_reg.unlocked, 16'h0000};
                default:     st_next.rdata = '0;
            endcase
        end
    end
    // ==========================================================
    // state register
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_reg          <= '0;
            st_reg.count    <= COUNT_RESET;
            st_reg.load     <= LOAD_RESET;
            st_reg.dbg_halt <= CONTROL_RESET[BIT_DBG_HALT];
            st_reg.irq_en   <= CONTROL_RESET[BIT_IRQ_EN];
            st_reg.rst_en   <= CONTROL_RESET[BIT_RST_EN];
            st_reg.cnt_en   <= CONTROL_RESET[BIT_CNT_EN];
            st_reg.clk_sel  <= CONTROL_RESET[BIT_CLK_SEL];
            st_reg.prs      <= CONTROL_RESET[PRS_MSB:0];
        end else begin
            st_reg <= st_next;
        end
    end
    assign BUS.rdata     = st_reg.rdata;
    assign BUS.wdt_reset = st_reg.rst_out;
    assign BUS.wdt_irq   = st_reg.irq_out;
    assign UNDERFLOW     = st_reg.flag;
    assign UNLOCKED      = st_reg.unlocked;
endmodule : wdc_device
`default_nettype wire

//--- src/wdc_host.sv
// controlling party: reset and interrupt sink, debug state, external
// clock source and a command engine that drives the device link
// assumes software on a plain port with read data one cycle later
`default_nettype none
module wdc_host (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // software port
    input  wire logic [7:0]  SW_ADDR,
    input  wire logic [31:0] SW_WDATA,
    input  wire logic        SW_WR,
    input  wire logic        SW_RD,
    output logic      [31:0] SW_RDATA,
    // system events
    output logic             WDT_RESET_REQ,
    output logic             WDT_IRQ,
    // link
    wdc_if.ctl               BUS
);
    import wdc_pkg::*;
    typedef struct packed {
        wdc_hstate_t state;
        logic        guarded;
        logic        is_read;
        logic [7:0]  dev_addr;
        logic [31:0] dev_wdata;
        logic [31:0] dev_rdata;
        logic        sys_en;
        logic        halted;
        logic        rst_seen;
        logic        refused;
        logic [7:0]  ext_div;
        logic [7:0]  ext_cnt;
        logic        ext_clk;
        logic [7:0]  b_addr;
        logic [31:0] b_wdata;
        logic        b_wr;
        logic        b_rd;
        logic [31:0] sw_rdata;
        logic        rst_req;
        logic        irq;
    } wdc_host_st_t;
    wdc_host_st_t st_reg;
    wdc_host_st_t st_next;
    logic         cmd_go;
    assign cmd_go = SW_WR && (SW_ADDR == HOFS_DEV_CMD) && (st_reg.state == HS_IDLE);
    always_comb begin
        st_next         = st_reg;
        st_next.b_wr    = 1'b0;
        st_next.b_rd    = 1'b0;
        st_next.rst_req = BUS.wdt_reset;
        st_next.irq     = BUS.wdt_irq;
        st_next.sw_rdata = '0;
        // ==========================================================
        // external clock from divider, stopped when divider is zero
        if (st_reg.ext_div != 8'h00) begin
            if (st_reg.ext_cnt >= st_reg.ext_div - 8'h01) begin
                st_next.ext_cnt = 8'h00;
                st_next.ext_clk = !st_reg.ext_clk;
            end else begin
                st_next.ext_cnt = st_reg.ext_cnt + 8'h01;
            end
        end
        // ==========================================================
        // software writes
        if (SW_WR) begin
            case (SW_ADDR)
                HOFS_CFG: begin
                    st_next.sys_en = SW_WDATA[0];
                    st_next.halted = SW_WDATA[1];
                end
                HOFS_DEV_ADDR:  st_next.dev_addr  = SW_WDATA[7:0];
                HOFS_DEV_WDATA: st_next.dev_wdata = SW_WDATA;
                HOFS_EXT_DIV:   st_next.ext_div   = SW_WDATA[7:0];
                HOFS_STATUS: begin
                    st_next.rst_seen = st_reg.rst_seen & !SW_WDATA[0];
                    st_next.refused  = st_reg.refused & !SW_WDATA[3];
                end
                default: begin
                end
            endcase
        end
        // set wins over the clear above
        if (BUS.wdt_reset) begin
            st_next.rst_seen = 1'b1;
        end
        // ==========================================================
        // command sequencer
        case (st_reg.state)
            HS_IDLE: begin
                if (cmd_go) begin
                    st_next.guarded = SW_WDATA[2];
                    st_next.is_read = SW_WDATA[1];
                    if (!SW_WDATA[1] && st_reg.dev_addr == OFS_LOAD && st_reg.dev_wdata == 32'h0) begin
                        st_next.refused = 1'b1;
                    end else if (SW_WDATA[2]) begin
                        st_next.b_addr  = OFS_ACCESS;
                        st_next.b_wdata = {16'h0000, KEY_UNLOCK};
                        st_next.b_wr    = 1'b1;
                        st_next.state   = HS_KEY;
                    end else if (SW_WDATA[1] | SW_WDATA[0]) begin
                        st_next.b_addr  = st_reg.dev_addr;
                        st_next.b_wdata = st_reg.dev_wdata;
                        st_next.b_wr    = !SW_WDATA[1];
                        st_next.b_rd    = SW_WDATA[1];
                        st_next.state   = HS_ACCESS;
                    end
                end
            end
            HS_KEY: begin
                st_next.b_addr  = st_reg.dev_addr;
                st_next.b_wdata = st_reg.dev_wdata;
                st_next.b_wr    = !st_reg.is_read;
                st_next.b_rd    = st_reg.is_read;
                st_next.state   = HS_ACCESS;
            end
            HS_ACCESS: begin
                if (st_reg.is_read) begin
                    st_next.state = HS_RDWAIT;
                end else if (st_reg.guarded) begin
                    st_next.b_addr  = OFS_ACCESS;
                    st_next.b_wdata = '0;
                    st_next.b_wr    = 1'b1;
                    st_next.state   = HS_RELOCK;
                end else begin
                    st_next.state = HS_IDLE;
                end
            end
            HS_RDWAIT: begin
                st_next.dev_rdata = BUS.rdata;
                if (st_reg.guarded) begin
                    st_next.b_addr  = OFS_ACCESS;
                    st_next.b_wdata = '0;
                    st_next.b_wr    = 1'b1;
                    st_next.state   = HS_RELOCK;
                end else begin
                    st_next.state = HS_IDLE;
                end
            end
            HS_RELOCK: st_next.state = HS_IDLE;
            default:   st_next.state = HS_IDLE;
        endcase
        // ==========================================================
        // software reads
        if (SW_RD) begin
            case (SW_ADDR)
                HOFS_CFG:       st_next.sw_rdata = {30'h0, st_reg.halted, st_reg.sys_en};
                HOFS_DEV_ADDR:  st_next.sw_rdata = {24'h0, st_reg.dev_addr};
                HOFS_DEV_WDATA: st_next.sw_rdata = st_reg.dev_wdata;
                HOFS_DEV_RDATA: st_next.sw_rdata = st_reg.dev_rdata;
                HOFS_STATUS:    st_next.sw_rdata = {28'h0, st_reg.refused, st_reg.state != HS_IDLE,
                                                    st_reg.irq, st_reg.rst_seen};
                HOFS_EXT_DIV:   st_next.sw_rdata = {24'h0, st_reg.ext_div};
                default:        st_next.sw_rdata = '0;
            endcase
        end
    end
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st_reg         <= '0;
            st_reg.state   <= HS_IDLE;
            st_reg.ext_div <= EXT_DIV_RESET;
        end else begin
            st_reg <= st_next;
        end
    end
    assign BUS.addr           = st_reg.b_addr;
    assign BUS.wdata          = st_reg.b_wdata;
    assign BUS.wr             = st_reg.b_wr;
    assign BUS.rd             = st_reg.b_rd;
    assign BUS.core_halted    = st_reg.halted;
    assign BUS.sys_rst_src_en = st_reg.sys_en;
    assign BUS.ext_clk        = st_reg.ext_clk;
    assign SW_RDATA           = st_reg.sw_rdata;
    assign WDT_RESET_REQ      = st_reg.rst_req;
    assign WDT_IRQ            = st_reg.irq;
endmodule : wdc_host
`default_nettype wire

//--- verif/wdc_asserts.sv
// concurrent checks on the watchdog device link
// assumes one clock; the bench instantiates it beside the link
`default_nettype none
module wdc_asserts
    import wdc_pkg::*;
(
    // clock and reset
    input wire logic        CLOCK,
    input wire logic        RST,
    // link
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        wdt_reset,
    input wire logic        wdt_irq,
    input wire logic        sys_rst_src_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    // ==========================================================
    // shadow of lock and enable, only what the link shows
    logic unl_reg;
    logic en_reg;
    logic clr;
    assign clr = wr && unl_reg && ((addr == OFS_LOAD && wdata != 32'h0)
                 || (addr == OFS_CONTROL && !(wdata[BIT_FLAG] && wdata[BIT_IRQ_EN])));
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            unl_reg <= 1'b0;
            en_reg  <= CONTROL_RESET[BIT_CNT_EN];
        end else if (wr && addr == OFS_ACCESS) begin
            unl_reg <= (wdata[15:0] == KEY_UNLOCK);
        end else if (wr && unl_reg && addr == OFS_CONTROL) begin
            en_reg <= wdata[BIT_CNT_EN];
        end
    end
    // ==========================================================
    // read steps, reset and interrupt checks
    sequence s_rd_at(logic [7:0] a);
        rd && addr == a;
    endsequence
    chk_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data outside answer cycle");
    chk_access_bits: assert property (s_rd_at(OFS_ACCESS) |=> rdata[15:0] == 16'h0 && rdata[31:17] == 15'h0)
        else $error("access read shows key bits");
    chk_unmapped_read: assert property (s_rd_at(8'h40) |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_reset_gated: assert property (wdt_reset |-> $past(sys_rst_src_en))
        else $error("reset without system enable");
    chk_reset_single: assert property (wdt_reset |=> !wdt_reset [*2])
        else $error("reset pulse too long");
    chk_irq_holds: assert property (wdt_irq && !clr && !$past(clr) |=> wdt_irq)
        else $error("interrupt dropped without clear");
    chk_off_no_reset: assert property (!en_reg && !$past(en_reg) |-> !wdt_reset)
        else $error("reset while disabled");
    chk_off_no_irq: assert property (!en_reg && !$past(en_reg) && !$past(wr) |-> !$rose(wdt_irq))
        else $error("interrupt while disabled");
endmodule : wdc_asserts
`default_nettype wire

//--- verif/tb_top.sv
// bench joining controller and device; software port driven here
// assumes peripheral clock is the bench clock
`default_nettype none
module tb_top;
    import wdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    logic        irq;
    logic        uf_pin;
    logic        unl_pin;
    logic        rst_q;
    logic        saw_rst = 1'b0;
    logic [31:0] v;
    logic [31:0] w;
    int          n_mismatch = 0;
    int          checked = 0;
    wdc_if link();
    wdc_device i_wdc_device (.CLOCK(clk), .RST(rst), .BUS(link.dev), .UNDERFLOW(uf_pin), .UNLOCKED(unl_pin));
    wdc_host i_wdc_host (.CLOCK(clk), .RST(rst), .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WR(sw_wr),
        .SW_RD(sw_rd), .SW_RDATA(sw_rdata), .WDT_RESET_REQ(rst_q), .WDT_IRQ(irq), .BUS(link.ctl));
    // reset request is a one-cycle pulse, so keep a sticky copy
    always @(posedge clk) if (rst_q) saw_rst <= 1'b1;
    wdc_asserts i_wdc_asserts (.CLOCK(clk), .RST(rst), .addr(link.addr), .wdata(link.wdata),
        .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .wdt_reset(link.wdt_reset),
        .wdt_irq(link.wdt_irq), .sys_rst_src_en(link.sys_rst_src_en));
    always #4 clk = ~clk;
    // ==========================================================
    // access tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask : put
    task automatic get(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask : get
    // bounded poll, a hung engine shows as a mismatch
    task automatic dev(input logic [2:0] cmd, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        put(HOFS_DEV_ADDR, {24'h0, a});
        put(HOFS_DEV_WDATA, d);
        put(HOFS_DEV_CMD, {29'h0, cmd});
        do begin
            get(HOFS_STATUS, w);
            n++;
        end while (w[2] !== 1'b0 && n < 20);
        check("idle", 32'(w[2]), 32'h0);
    endtask : dev
    task automatic rdev(input logic [7:0] a, output logic [31:0] d);
        dev(3'h2, a, 32'h0);
        get(HOFS_DEV_RDATA, d);
    endtask : rdev
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
    // ==========================================================
    // tests
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdev(OFS_CONTROL, v);
        check("control reset", v, CONTROL_RESET);
        rdev(OFS_ACCESS, v);
        check("locked", v, 32'h0);
        rdev(8'h40, v);
        check("unmapped", v, 32'h0);
        check("unlocked pin", 32'(unl_pin), 32'h0);
        $display("test defaults done");
        dev(3'h5, OFS_CONTROL, 32'h90);
        dev(3'h5, OFS_LOAD, 32'd200);
        check("irq early", 32'(irq), 32'h0);
        for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk);
        check("irq raised", 32'(irq), 32'h1);
        check("flag pin", 32'(uf_pin), 32'h1);
        rdev(OFS_CONTROL, v);
        check("flag", 32'(v[BIT_FLAG]), 32'h1);
        rdev(OFS_COUNT, v);
        check("auto reload", 32'(v != 32'h0), 32'h1);
        dev(3'h1, OFS_CONTROL, 32'h0);
        rdev(OFS_CONTROL, v);
        check("locked write", 32'(v[BIT_CNT_EN]), 32'h1);
        dev(3'h5, OFS_LOAD, 32'd200);
        check("flag cleared", 32'(irq), 32'h0);
        dev(3'h5, OFS_CONTROL, 32'h0);
        rdev(OFS_COUNT, v);
        rdev(OFS_COUNT, w);
        check("disabled hold", w, v);
        $display("test interrupt mode done");
        dev(3'h5, OFS_CONTROL, 32'h50);
        dev(3'h5, OFS_LOAD, 32'd20);
        repeat (60) @(posedge clk);
        rdev(OFS_COUNT, v);
        check("count stays zero", v, 32'h0);
        get(HOFS_STATUS, v);
        check("no system reset", 32'(v[0]), 32'h0);
        dev(3'h1, OFS_ACCESS, {16'h0, KEY_RELOAD});
        rdev(OFS_COUNT, v);
        check("reload key", 32'(v != 32'h0 && v <= 32'd20), 32'h1);
        put(HOFS_CFG, 32'h1);
        dev(3'h5, OFS_LOAD, 32'd20);
        repeat (60) @(posedge clk);
        get(HOFS_STATUS, v);
        check("reset seen", 32'(v[0]), 32'h1);
        check("reset pin", 32'(saw_rst), 32'h1);
        $display("test reset mode done");
        put(HOFS_CFG, 32'h0);
        dev(3'h5, OFS_CONTROL, 32'h8010);
        dev(3'h5, OFS_LOAD, 32'd200);
        put(HOFS_CFG, 32'h2);
        rdev(OFS_COUNT, v);
        rdev(OFS_COUNT, w);
        check("frozen", w, v);
        dev(3'h5, OFS_CONTROL, 32'h10);
        rdev(OFS_COUNT, v);
        rdev(OFS_COUNT, w);
        check("runs in debug", 32'(w < v), 32'h1);
        $display("test debug done");
        dev(3'h5, OFS_LOAD, 32'h0);
        get(HOFS_STATUS, v);
        check("zero load refused", 32'(v[3]), 32'h1);
        dev(3'h5, OFS_CONTROL, 32'h11);
        dev(3'h5, OFS_LOAD, 32'd200);
        // wait out the five-tick load transfer at divide by four
        repeat (24) @(posedge clk);
        rdev(OFS_COUNT, v);
        repeat (40) @(posedge clk);
        rdev(OFS_COUNT, w);
        // reads are 52 cycles apart, so 13 ticks at divide by four
        check("prescale by four", v - w, 32'd13);
        $display("test prescale done");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
